// ===== src/asr_ctrl.sv
// Controller that drives a 32K x 8 asynchronous static memory through its pins
`timescale 1ns/1ps
// What this block does
// RULE_01: Memory is static; controller only sequences pins, no refresh issued.
// RULE_02: Select high puts memory in standby; controller deasserts select when idle.
// RULE_03: Reads keep write enable high with select low and drive low.
// RULE_04: Read data sampled only after full address-to-data time.
// RULE_05: Select falls with address stable; data waited the same full time.
// RULE_06: Drive enable low during whole read window before sampling.
// RULE_07: After read, wait release time before controller drives byte lines.
// RULE_08: Data sampled before address changes, so hold window is respected.
// RULE_09: Address is stable before select falls for every access.
// RULE_10: Write pulse long enough; select and address held through it.
// RULE_11: Write enable kept low the minimum pulse; zero address setup allowed.
// RULE_12: Write data set up before strobe rise and held afterwards.
// RULE_13: Drive enable kept high during writes, so memory drivers stay off.
// RULE_14: Drive enable stays high after a write until next read.
// RULE_15: Select held high through retention; recovery wait before first access. An access begun before the retention sync still runs, select low.
// RULE_16: Write ends by write enable rising first while select stays low.
// RULE_17: Address only changes while select and write enable are high.
// RULE_18: Select and write enable fall together; memory stays high impedance.
// RULE_19: Write pulse stretched to release time plus data setup.
// RULE_20: Fifteen address bits and eight data bits moved in parallel.
// RULE_21: Idle select low state never used; lines left released.
module asr_ctrl
   import asr_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              req_valid_in,
   input  wire logic              req_write_in,
   input  wire logic [ADDR_W-1:0] req_addr_in,
   input  wire logic [DATA_W-1:0] req_wdata_in,
   input  wire logic              retention_in,
   output logic                   req_ready_out,
   output logic                   rsp_valid_out,
   output logic      [DATA_W-1:0] rsp_rdata_out,
   output logic      [ADDR_W-1:0] word_address_out,
   output logic                   select_n_out,
   output logic                   write_n_out,
   output logic                   drive_n_out,
   input  wire logic [DATA_W-1:0] byte_lines_in,
   output logic      [DATA_W-1:0] byte_lines_out,
   output logic                   byte_lines_oe_out
);

   ////////////////////////////////////////////////////////////////////////////
   asr_state_e        state_r, state_nxt;
   logic [CNT_W-1:0]  cnt_r, cnt_nxt;
   logic              ret_s1_r, ret_s2_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wdata_r, rdata_r;
   logic [DATA_W-1:0] bl_s1_r, bl_s2_r;
   logic              rvalid_r;
   logic              write_r;

   wire logic cnt_done = (cnt_r == '0);
   wire logic take     = (state_r == ST_IDLE) && req_valid_in && !ret_s2_r;

   assign req_ready_out     = (state_r == ST_IDLE) && !ret_s2_r;
   assign word_address_out  = addr_r;
   assign rsp_rdata_out     = rdata_r;
   assign rsp_valid_out     = rvalid_r;
   assign byte_lines_out    = wdata_r;
   // Select low in read, read release, write pulse and write hold; high in idle, recovery, retention and both setup states
   assign select_n_out      = (state_r == ST_IDLE) || (state_r == ST_RECOV) || (state_r == ST_RSET) ||
                              (state_r == ST_WSET); // RULE_02 RULE_09 RULE_15 RULE_17
   assign write_n_out       = (state_r != ST_WPULSE); // RULE_16 RULE_18
   assign drive_n_out       = (state_r != ST_READ); // RULE_06 RULE_13 RULE_14 RULE_21
   assign byte_lines_oe_out = (state_r == ST_WPULSE) || (state_r == ST_WHOLD); // RULE_12

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_done ? cnt_r : cnt_r - 1'b1;
      case (state_r)
         ST_IDLE: begin
            if (take) begin
               state_nxt = req_write_in ? ST_WSET : ST_RSET; // RULE_20
            end
         end
         ST_RSET: begin
            state_nxt = ST_READ; // RULE_03 RULE_05
            cnt_nxt   = CNT_W'(READ_CYC - 1);
         end
         ST_READ: begin
            if (cnt_done) begin
               state_nxt = ST_RREL; // RULE_04 RULE_08
               cnt_nxt   = CNT_W'(RDREL_CYC - 1);
            end
         end
         ST_RREL: begin
            if (cnt_done) begin
               state_nxt = ST_IDLE; // RULE_07
            end
         end
         ST_WSET: begin
            state_nxt = ST_WPULSE; // RULE_11
            cnt_nxt   = CNT_W'(WPULSE_CYC - 1);
         end
         ST_WPULSE: begin
            if (cnt_done) begin
               state_nxt = ST_WHOLD; // RULE_10 RULE_19
               cnt_nxt   = CNT_W'(WHOLD_CYC - 1);
            end
         end
         ST_WHOLD: begin
            if (cnt_done) begin
               state_nxt = ST_IDLE; // RULE_12
            end
         end
         ST_RECOV: begin
            if (ret_s2_r) begin
               cnt_nxt = CNT_W'(RECOV_CYC - 1);
            end else if (cnt_done) begin
               state_nxt = ST_IDLE; // RULE_15
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (state_r == ST_IDLE && ret_s2_r) begin
         state_nxt = ST_RECOV; // RULE_15
         cnt_nxt   = CNT_W'(RECOV_CYC - 1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r  <= ST_IDLE;
         cnt_r    <= '0;
         ret_s1_r <= 1'b0;
         ret_s2_r <= 1'b0;
         bl_s1_r  <= '0;
         bl_s2_r  <= '0;
      end else begin
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         ret_s1_r <= retention_in;
         ret_s2_r <= ret_s1_r;
         bl_s1_r  <= byte_lines_in;
         bl_s2_r  <= bl_s1_r;
      end
   end

   // Address and write data held for the whole access
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         addr_r  <= '0;
         wdata_r <= '0;
         write_r <= 1'b0;
      end else if (take) begin
         addr_r  <= req_addr_in; // RULE_17
         wdata_r <= req_wdata_in;
         write_r <= req_write_in;
      end
   end

   // Synchronised byte captured in the first cycle of the release wait, while address is still held
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_r  <= '0;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= 1'b0;
         if (state_r == ST_RREL && cnt_r == CNT_W'(RDREL_CYC - 1)) begin
            rdata_r  <= bl_s2_r; // RULE_08
            rvalid_r <= !write_r;
         end
      end
   end

endmodule : asr_ctrl

// ===== src/asr_pkg.sv
// Package of pin timing constants for the static memory controller
package asr_pkg;
   localparam int CLK_PERIOD_PS      = 5000;
   localparam int ADDR_W             = 15;
   localparam int DATA_W             = 8;
   // Slow grade figures in ns, all minimums
   localparam int READ_PERIOD_NS     = 35;
   localparam int ADDR_TO_DATA_NS    = 35;
   localparam int DRIVE_RELEASE_NS   = 15;
   localparam int WRITE_PERIOD_NS    = 35;
   localparam int WRITE_PULSE_NS     = 30;
   localparam int WRITE_RELEASE_NS   = 15;
   localparam int DATA_SETUP_NS      = 15;
   localparam int DATA_HOLD_NS       = 3;
   localparam int RECOVERY_NS        = 35;

   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc

   localparam int READ_CYC     = ns_to_cyc(ADDR_TO_DATA_NS + 5);
   localparam int RDREL_CYC    = ns_to_cyc(DRIVE_RELEASE_NS);
   localparam int WPULSE_CYC   = ns_to_cyc(WRITE_RELEASE_NS + DATA_SETUP_NS) > ns_to_cyc(WRITE_PULSE_NS) ?
                                 ns_to_cyc(WRITE_RELEASE_NS + DATA_SETUP_NS) : ns_to_cyc(WRITE_PULSE_NS);
   localparam int WHOLD_CYC    = ns_to_cyc(DATA_HOLD_NS);
   localparam int RECOV_CYC    = ns_to_cyc(RECOVERY_NS);
   localparam int CNT_W        = 4;

   typedef enum logic [2:0] {ST_IDLE, ST_RSET, ST_READ, ST_RREL, ST_WSET, ST_WPULSE, ST_WHOLD,
                             ST_RECOV} asr_state_e;
endpackage : asr_pkg

// ===== sim/asr_ctrl_properties.sv
// Checker of the controller pin sequencing
`timescale 1ns/1ps
module asr_ctrl_properties import asr_pkg::*; (
   input wire logic clk_in, rst_n_in, req_valid_in, req_write_in, retention_in, req_ready_out, rsp_valid_out,
   input wire logic select_n_out, write_n_out, drive_n_out, byte_lines_oe_out,
   input wire logic [ADDR_W-1:0] word_address_out,
   input wire logic [DATA_W-1:0] byte_lines_out);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_RD_WE: assert property (!drive_n_out |-> write_n_out && !select_n_out) else $error("bad read");
   AST_AD: assert property (!$stable(word_address_out) |-> select_n_out) else $error("addr moved");
   AST_WP: assert property ($fell(write_n_out) |-> (!write_n_out)[*6] ##1 write_n_out) else $error("pulse");
   AST_WS: assert property (!write_n_out |-> !select_n_out && drive_n_out && byte_lines_oe_out)
      else $error("bad write");
   AST_DH: assert property ($rose(write_n_out) |-> byte_lines_oe_out && $stable(byte_lines_out))
      else $error("hold");
   AST_OE: assert property (byte_lines_oe_out |-> drive_n_out) else $error("contention");
   AST_RL: assert property ($fell(drive_n_out) |-> (!drive_n_out)[*8] ##1 drive_n_out) else $error("rd");
   AST_RT: assert property ($fell(retention_in) |-> (!req_ready_out)[*8]) else $error("recovery");
   AST_RS: assert property (req_valid_in && req_ready_out && !req_write_in |-> ##11 rsp_valid_out)
      else $error("rsp");
endmodule : asr_ctrl_properties

// ===== sim/asr_sram_model.sv
// Behavioural 32K x 8 static memory
`timescale 1ns/1ps
module asr_sram_model import asr_pkg::*; (
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic cs_n_in, we_n_in, oe_n_in,
   input wire logic [DATA_W-1:0] bus_in,
   output logic [DATA_W-1:0] q_out);
   logic [DATA_W-1:0] mem [0:32767];
   logic [DATA_W-1:0] last = 8'h00;
   wire drv = !cs_n_in && we_n_in && !oe_n_in;
   always @(posedge we_n_in or posedge cs_n_in) if (we_n_in ^ cs_n_in) mem[addr_in] <= bus_in;
   always @* if (drv) last = mem[addr_in];
   // Released lines show the inverse of the last byte
   assign #15 q_out = drv ? mem[addr_in] : ~last;
endmodule : asr_sram_model

// ===== sim/asr_ctrl_tb_top.sv
// Testbench of the static memory controller
`timescale 1ns/1ps
module asr_ctrl_tb_top import asr_pkg::*;;
   logic clk_in = 0, rst_n_in = 0, req_valid_in = 0, req_write_in = 0, retention_in = 0;
   logic [ADDR_W-1:0] req_addr_in = '0, word_address_out;
   logic [DATA_W-1:0] req_wdata_in = '0, byte_lines_in, byte_lines_out, rsp_rdata_out, q;
   logic req_ready_out, rsp_valid_out, select_n_out, write_n_out, drive_n_out, byte_lines_oe_out;
   logic [ADDR_W-1:0] ta [4] = '{15'h0000, 15'h7FFF, 15'h5555, 15'h2AAA};
   logic [DATA_W-1:0] td [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
   int error_cnt = 0, tests_run = 0, cyc = 0;
   asr_ctrl u_asr_ctrl (.*);
   asr_sram_model u_asr_sram_model (.addr_in(word_address_out), .cs_n_in(select_n_out), .we_n_in(write_n_out),
      .oe_n_in(drive_n_out), .bus_in(byte_lines_in), .q_out(q));
   assign byte_lines_in = byte_lines_oe_out ? byte_lines_out : q;
   initial forever #2.5 clk_in = ~clk_in;
   always @(posedge clk_in) if (++cyc == 3000) begin
      error_cnt++;
      finish_test;
   end
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic req(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      int n;
      @(negedge clk_in);
      {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, w, a, d};
      n = 0;
      while (req_ready_out !== 1'b1 && ++n < 50) @(negedge clk_in);
      @(negedge clk_in);
      req_valid_in = 0;
      n = 0;
      if (!w) while (rsp_valid_out !== 1'b1 && ++n < 50) @(negedge clk_in);
      if (!w) chk("read data", rsp_rdata_out, d);
   endtask : req
   task automatic t_reset;
      chk("reset pins", {select_n_out, write_n_out, drive_n_out, byte_lines_oe_out, req_ready_out}, 5'h1D);
   endtask : t_reset
   task automatic t_rw;
      for (int i = 0; i < 4; i++) req(1, ta[i], td[i]);
      for (int i = 3; i >= 0; i--) req(0, ta[i], td[i]);
      req(1, ta[1], 8'h3C);
      req(0, ta[1], 8'h3C);
   endtask : t_rw
   task automatic t_ret;
      @(negedge clk_in);
      retention_in = 1;
      repeat (6) @(negedge clk_in);
      chk("ready in retention", req_ready_out, 1'b0);
      chk("select in retention", select_n_out, 1'b1);
      retention_in = 0;
      repeat (6) @(negedge clk_in);
      chk("ready in recovery", req_ready_out, 1'b0);
      req(0, ta[2], td[2]);
   endtask : t_ret
   task automatic finish_test;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   initial begin
      repeat (2) @(negedge clk_in);
      rst_n_in = 1;
      t_reset;
      t_rw;
      t_ret;
      finish_test;
   end
endmodule : asr_ctrl_tb_top
bind asr_ctrl asr_ctrl_properties u_asr_ctrl_properties (.*);
